// ---- logic/byte_shifter.sv ----
/*
   msb-first shift register for the serial and I2C frames.
   assumes load and shift never come in the same cycle.
*/
`timescale 1ns/1ps
`default_nettype none
module byte_shifter
#(
   parameter int W = 8
)
(
   // clock and reset
   input  wire logic         i_clk,
   input  wire logic         i_rst,
   // control
   input  wire logic         i_load,
   input  wire logic [W-1:0] i_data,
   input  wire logic         i_shift,
   // output
   output logic              o_msb
);

   logic [W-1:0] data_ff;

   // load wins; a shift pulls in zero at the bottom
   always_ff @(posedge i_clk or posedge i_rst)
   begin
      if (i_rst)
         data_ff <= '0;
      else if (i_load)
         data_ff <= i_data;
      else if (i_shift)
         data_ff <= {data_ff[W-2:0], 1'b0};
   end

   assign o_msb = data_ff[W-1];

endmodule
`default_nettype wire

// ---- logic/host_pkg.sv ----
/*
   constants, types and register map of the display host controller.
   assumes a 20 MHz system clock and a display module on the far side
   that follows the pin behaviour summarised below.
*/
// Function
// R1 - straps: low0/high1 6800, both high 8080, both low serial, low1/high0 I2C
// R2 - device takes transfers only while chip select is held low
// R3 - reset pin low runs device initialisation; held high in normal use
// R4 - data/command pin high sends display data, low sends a command byte
// R5 - in I2C mode the data/command pin is slave address bit 0
// R6 - 6800 mode: read/write pin high reads, low writes
// R7 - 8080 mode: read/write pin is an active-low write strobe
// R8 - 6800 mode: enable pin high starts the access
// R9 - 8080 mode: enable pin is an active-low read strobe
// R10 - serial modes: read/write and enable pins are held low
// R11 - clocked serial: line 0 clock, line 1 data, line 2 left undriven
// R12 - I2C: line 0 clock, lines 1 and 2 tied as the data wire
// R13 - parallel modes: 8-bit two-way bus, device drives only on reads
// R14 - clocked serial: device samples on rising clock, msb first
package host_pkg;

   // ----------------------------------------------------------------
   // software register map (byte addresses)
   // ----------------------------------------------------------------
   localparam logic [7:0] ADDR_CTRL   = 8'h00;
   localparam logic [7:0] ADDR_STATUS = 8'h04;
   localparam logic [7:0] ADDR_TXDATA = 8'h08;
   localparam logic [7:0] ADDR_CMD    = 8'h0c;
   localparam logic [7:0] ADDR_RXDATA = 8'h10;

   // control register fields
   localparam int CTRL_SEL_LOW  = 0;
   localparam int CTRL_SEL_HIGH = 1;
   localparam int CTRL_DC       = 2;
   localparam int CTRL_HOLD_RST = 3;
   localparam int CTRL_I2C_DATA = 4;
   localparam logic [4:0] CTRL_RESET = 5'h08; // device held in reset

   // status register fields
   localparam int STAT_BUSY = 0;
   localparam int STAT_NACK = 1;
   localparam int STAT_RST  = 2;

   // command register field
   localparam int CMD_READ = 0;

   // ----------------------------------------------------------------
   // protocol strap codes, written {high, low}
   // ----------------------------------------------------------------
   localparam logic [1:0] MODE_6800   = 2'h2;
   localparam logic [1:0] MODE_8080   = 2'h3;
   localparam logic [1:0] MODE_SERIAL = 2'h0;
   localparam logic [1:0] MODE_I2C    = 2'h1;

   // ----------------------------------------------------------------
   // timing
   // ----------------------------------------------------------------
   localparam int CLK_NS     = 50;
   localparam int PHASE_NS   = 200;   // parallel and serial phase
   localparam int I2C_PH_NS  = 2500;  // 200 kHz I2C half period
   localparam int PHASE_CYC  = (PHASE_NS + CLK_NS - 1) / CLK_NS;
   localparam int I2C_PH_CYC = (I2C_PH_NS + CLK_NS - 1) / CLK_NS;
   localparam int TMR_W      = 8;

   // bit and byte counts of one frame
   localparam logic [3:0] SER_BITS  = 4'h8;
   localparam logic [3:0] I2C_BITS  = 4'h9;  // eight data plus ack
   localparam logic [1:0] I2C_LAST  = 2'h2;  // address, control, data
   localparam int         ACK_BIT   = 8;

   // I2C framing values (address bit 0 comes from the data/command bit)
   localparam logic [5:0] I2C_ADDR_BASE = 6'h1e;
   localparam logic [7:0] I2C_CTRL_CMD  = 8'h00;
   localparam logic [7:0] I2C_CTRL_DATA = 8'h40;

   // ----------------------------------------------------------------
   // device pin bundle (all levels as seen on the wire)
   // ----------------------------------------------------------------
   typedef struct packed {
      logic protocol_select_low;
      logic protocol_select_high;
      logic cs_n;
      logic reset_n_input;
      logic dc;
      logic rw;
      logic e_rd;
   } pins_s;

endpackage

// ---- logic/oled_host_ctrl.sv ----
/*
   host controller for the display module's host port: drives the
   straps, chip select, reset, data/command and strobe pins and the
   eight shared data lines in 6800, 8080, clocked serial or I2C style.
   assumes software on a plain register port (read data one cycle after
   the read strobe) and an outside wire model that resolves the data
   lines from the output enables, which are low while driving.
*/
// The strobed register port and the register offsets were decided locally.
`timescale 1ns/1ps
`default_nettype none
module oled_host_ctrl
(
   // clock and reset
   input  wire logic                  i_clk,
   input  wire logic                  i_rst,
   // software register port
   input  wire logic [7:0]            i_addr,
   input  wire logic [31:0]           i_wdata,
   input  wire logic                  i_wr,
   input  wire logic                  i_rd,
   output logic      [31:0]           o_rdata,
   // device control pins
   output host_pkg::pins_s            o_pins,
   // device data lines
   input  wire logic [7:0]            i_bus_in,
   output logic      [7:0]            o_bus_out,
   output logic      [7:0]            o_bus_oe_n
);

   // ----------------------------------------------------------------
   // declarations
   // ----------------------------------------------------------------
   typedef enum logic [3:0] {
      ST_IDLE,
      ST_PSETUP,
      ST_PSTROBE,
      ST_PHOLD,
      ST_I2C_START,
      ST_BIT_LO,
      ST_BIT_HI,
      ST_STOP_LO,
      ST_STOP_HI
   } state_e;

   state_e          state_ff;
   state_e          nxt_state;
   logic [4:0]      ctrl_ff;
   logic [7:0]      tx_ff;
   logic [7:0]      rx_ff;
   logic            nack_ff;
   logic            is_read_ff;
   logic [3:0]      bit_ff;
   logic [1:0]      byte_ff;
   logic [31:0]     rdata_ff;
   host_pkg::pins_s pins_ff;
   host_pkg::pins_s nxt_pins;
   logic [7:0]      bus_out_ff;
   logic [7:0]      nxt_bus_out;
   logic [7:0]      bus_oe_n_ff;
   logic [7:0]      nxt_bus_oe_n;

   logic [1:0]      mode;
   logic            parallel;
   logic            is_i2c;
   logic            busy;
   logic            go_wr;
   logic            go_rd;
   logic            start;
   logic            done;
   logic            first;
   logic            last_bit;
   logic            bit_end;
   logic            frame_end;
   logic            shift;
   logic            load;
   logic [7:0]      load_val;
   logic [3:0]      frame_bits;
   logic [7:0]      phase_len;
   logic            msb;
   logic            sda_in;

   // ----------------------------------------------------------------
   // decoding of mode and software requests
   // ----------------------------------------------------------------
   assign mode     = {ctrl_ff[host_pkg::CTRL_SEL_HIGH],
                      ctrl_ff[host_pkg::CTRL_SEL_LOW]};
   assign parallel = (mode == host_pkg::MODE_6800) ||
                     (mode == host_pkg::MODE_8080);
   assign is_i2c   = (mode == host_pkg::MODE_I2C);
   assign busy     = (state_ff != ST_IDLE);

   // no transfer while the device is held in reset or one is running
   assign go_wr = i_wr && (i_addr == host_pkg::ADDR_TXDATA) && !busy &&
                  !ctrl_ff[host_pkg::CTRL_HOLD_RST];
   assign go_rd = i_wr && (i_addr == host_pkg::ADDR_CMD) && !busy &&
                  i_wdata[host_pkg::CMD_READ] && parallel &&
                  !ctrl_ff[host_pkg::CTRL_HOLD_RST]; // R13
   assign start = go_wr || go_rd;

   // the data line 1 is the tied data wire in I2C mode
   assign sda_in = i_bus_in[1]; // R12

   assign frame_bits = is_i2c ? host_pkg::I2C_BITS : host_pkg::SER_BITS;
   assign last_bit   = (bit_ff == frame_bits - 4'h1);
   assign bit_end    = (state_ff == ST_BIT_HI) && done;
   assign frame_end  = bit_end && last_bit &&
                       (!is_i2c || byte_ff == host_pkg::I2C_LAST);
   assign phase_len  = is_i2c ? 8'(host_pkg::I2C_PH_CYC)
                              : 8'(host_pkg::PHASE_CYC);

   // ----------------------------------------------------------------
   // phase pacing and serial shifting
   // ----------------------------------------------------------------
   phase_timer #(.W(host_pkg::TMR_W)) u_timer
   (
      .i_clk     (i_clk),
      .i_rst     (i_rst),
      .i_restart (nxt_state != state_ff),
      .i_len     (phase_len),
      .o_done    (done),
      .o_first   (first)
   );

   // first byte of an I2C frame is the address, then control, then data
   always_comb
   begin
      load_val = tx_ff;
      if (is_i2c && state_ff == ST_IDLE)
         load_val = {host_pkg::I2C_ADDR_BASE,
                     ctrl_ff[host_pkg::CTRL_DC], 1'b0}; // R5
      else if (is_i2c && byte_ff == 2'h0)
         load_val = ctrl_ff[host_pkg::CTRL_I2C_DATA] ?
                    host_pkg::I2C_CTRL_DATA : host_pkg::I2C_CTRL_CMD;
   end

   assign load  = (go_wr && !parallel) ||
                  (bit_end && last_bit && !frame_end);
   assign shift = bit_end && !last_bit;

   byte_shifter #(.W(8)) u_shift
   (
      .i_clk   (i_clk),
      .i_rst   (i_rst),
      .i_load  (load),
      .i_data  (go_wr && !is_i2c ? i_wdata[7:0] : load_val),
      .i_shift (shift),
      .o_msb   (msb)
   );

   // ----------------------------------------------------------------
   // transfer sequencer
   // ----------------------------------------------------------------
   always_comb
   begin
      nxt_state = state_ff;
      unique case (state_ff)
         ST_IDLE:
            if (start)
            begin
               if (parallel)
                  nxt_state = ST_PSETUP;
               else if (is_i2c)
                  nxt_state = ST_I2C_START;
               else
                  nxt_state = ST_BIT_LO;
            end
         ST_PSETUP:    if (done) nxt_state = ST_PSTROBE;
         ST_PSTROBE:   if (done) nxt_state = ST_PHOLD;
         ST_PHOLD:     if (done) nxt_state = ST_IDLE;
         ST_I2C_START: if (done) nxt_state = ST_BIT_LO;
         ST_BIT_LO:    if (done) nxt_state = ST_BIT_HI;
         ST_BIT_HI:
            if (done)
            begin
               if (!frame_end)
                  nxt_state = ST_BIT_LO;
               else if (is_i2c)
                  nxt_state = ST_STOP_LO;
               else
                  nxt_state = ST_IDLE;
            end
         ST_STOP_LO:   if (done) nxt_state = ST_STOP_HI;
         ST_STOP_HI:   if (done) nxt_state = ST_IDLE;
      endcase
   end

   always_ff @(posedge i_clk or posedge i_rst)
   begin
      if (i_rst)
         state_ff <= ST_IDLE;
      else
         state_ff <= nxt_state;
   end

   // bit and byte position within a serial frame
   always_ff @(posedge i_clk or posedge i_rst)
   begin
      if (i_rst)
      begin
         bit_ff  <= '0;
         byte_ff <= '0;
      end
      else if (start)
      begin
         bit_ff  <= '0;
         byte_ff <= '0;
      end
      else if (bit_end)
      begin
         bit_ff  <= last_bit ? 4'h0 : bit_ff + 4'h1;
         byte_ff <= last_bit ? byte_ff + 2'h1 : byte_ff;
      end
   end

   // ----------------------------------------------------------------
   // software registers
   // ----------------------------------------------------------------
   // straps, data/command and reset hold only change while idle
   always_ff @(posedge i_clk or posedge i_rst)
   begin
      if (i_rst)
         ctrl_ff <= host_pkg::CTRL_RESET;
      else if (i_wr && i_addr == host_pkg::ADDR_CTRL && !busy)
         ctrl_ff <= i_wdata[4:0];
   end

   // write byte and direction of the running transfer
   always_ff @(posedge i_clk or posedge i_rst)
   begin
      if (i_rst)
      begin
         tx_ff      <= '0;
         is_read_ff <= 1'b0;
      end
      else if (start)
      begin
         tx_ff      <= go_wr ? i_wdata[7:0] : tx_ff;
         is_read_ff <= go_rd;
      end
   end

   // read byte taken at the close of the strobe, while still active
   always_ff @(posedge i_clk or posedge i_rst)
   begin
      if (i_rst)
         rx_ff <= '0;
      else if (state_ff == ST_PSTROBE && done && is_read_ff)
         rx_ff <= i_bus_in; // R13
   end

   // missing acknowledge is sticky; a new one beats the clear
   always_ff @(posedge i_clk or posedge i_rst)
   begin
      if (i_rst)
         nack_ff <= 1'b0;
      else if (is_i2c && bit_end && bit_ff == 4'(host_pkg::ACK_BIT) &&
               sda_in)
         nack_ff <= 1'b1;
      else if (i_wr && i_addr == host_pkg::ADDR_STATUS &&
               i_wdata[host_pkg::STAT_NACK])
         nack_ff <= 1'b0;
   end

   // read data stand for the one cycle after the strobe
   always_ff @(posedge i_clk or posedge i_rst)
   begin
      if (i_rst)
         rdata_ff <= '0;
      else if (!i_rd)
         rdata_ff <= '0;
      else
         unique case (i_addr)
            host_pkg::ADDR_CTRL:   rdata_ff <= {27'h0, ctrl_ff};
            host_pkg::ADDR_STATUS: rdata_ff <= {29'h0,
                                     ctrl_ff[host_pkg::CTRL_HOLD_RST],
                                     nack_ff, busy};
            host_pkg::ADDR_RXDATA: rdata_ff <= {24'h0, rx_ff};
            default:               rdata_ff <= '0;
         endcase
   end

   assign o_rdata = rdata_ff;

   // ----------------------------------------------------------------
   // pin levels
   // ----------------------------------------------------------------
   // levels follow the state one cycle later, so all pins move together
   always_comb
   begin
      nxt_pins                      = '0;
      nxt_pins.protocol_select_low  = mode[0]; // R1
      nxt_pins.protocol_select_high = mode[1]; // R1
      nxt_pins.cs_n                 = 1'b1; // R2
      nxt_pins.reset_n_input        =
         !ctrl_ff[host_pkg::CTRL_HOLD_RST]; // R3
      nxt_pins.dc                   = ctrl_ff[host_pkg::CTRL_DC]; // R4 R5
      nxt_bus_out                   = '0;
      nxt_bus_oe_n                  = 8'hff;
      unique case (mode)
         host_pkg::MODE_6800:
         begin
            if (state_ff inside {ST_PSETUP, ST_PSTROBE, ST_PHOLD})
            begin
               nxt_pins.cs_n = 1'b0; // R2
               nxt_pins.rw   = is_read_ff; // R6
               nxt_pins.e_rd = (state_ff == ST_PSTROBE); // R8
               if (!is_read_ff)
               begin
                  nxt_bus_out  = tx_ff; // R13
                  nxt_bus_oe_n = 8'h00;
               end
            end
         end
         host_pkg::MODE_8080:
         begin
            // strobes idle high; both low would be an illegal access
            nxt_pins.rw   = 1'b1;
            nxt_pins.e_rd = 1'b1;
            if (state_ff inside {ST_PSETUP, ST_PSTROBE, ST_PHOLD})
            begin
               nxt_pins.cs_n = 1'b0; // R2
               nxt_pins.rw   = !(state_ff == ST_PSTROBE &&
                                 !is_read_ff); // R7
               nxt_pins.e_rd = !(state_ff == ST_PSTROBE &&
                                 is_read_ff); // R9
               if (!is_read_ff)
               begin
                  nxt_bus_out  = tx_ff; // R13
                  nxt_bus_oe_n = 8'h00;
               end
            end
         end
         host_pkg::MODE_SERIAL:
         begin
            // strobe pins stay low; line 2 and up are left undriven
            nxt_bus_oe_n = 8'hfc; // R10 R11
            if (state_ff inside {ST_BIT_LO, ST_BIT_HI})
            begin
               nxt_pins.cs_n  = 1'b0; // R2
               nxt_bus_out[0] = (state_ff == ST_BIT_HI); // R14
               // data moves only after the falling clock edge
               nxt_bus_out[1] = (state_ff == ST_BIT_LO && first) ?
                                bus_out_ff[1] : msb; // R14
            end
         end
         host_pkg::MODE_I2C:
         begin
            // open drain: a line is pulled low by enabling a zero
            nxt_pins.cs_n   = !busy; // R2
            nxt_bus_oe_n[0] = !(state_ff inside {ST_BIT_LO,
                                ST_STOP_LO}); // R12
            unique case (state_ff)
               ST_I2C_START, ST_STOP_HI:
                  nxt_bus_oe_n[1] = 1'b0;
               ST_STOP_LO:
                  nxt_bus_oe_n[1] = first ? bus_oe_n_ff[1] : 1'b0;
               ST_BIT_LO:
                  // hold data over the falling clock edge
                  nxt_bus_oe_n[1] = first ? bus_oe_n_ff[1] :
                     (last_bit || msb); // R12
               ST_BIT_HI:
                  nxt_bus_oe_n[1] = last_bit || msb; // R12
               default:
                  nxt_bus_oe_n[1] = 1'b1;
            endcase
         end
      endcase
   end

   always_ff @(posedge i_clk or posedge i_rst)
   begin
      if (i_rst)
      begin
         pins_ff     <= '{protocol_select_low: 1'b0,
                          protocol_select_high: 1'b0,
                          cs_n: 1'b1, reset_n_input: 1'b0,
                          dc: 1'b0, rw: 1'b0, e_rd: 1'b0};
         bus_out_ff  <= '0;
         bus_oe_n_ff <= 8'hff;
      end
      else
      begin
         pins_ff     <= nxt_pins;
         bus_out_ff  <= nxt_bus_out;
         bus_oe_n_ff <= nxt_bus_oe_n;
      end
   end

   assign o_pins     = pins_ff;
   assign o_bus_out  = bus_out_ff;
   assign o_bus_oe_n = bus_oe_n_ff;

endmodule
`default_nettype wire

// ---- logic/phase_timer.sv ----
/*
   cycle counter that paces each phase of a transfer.
   assumes the caller restarts it on every state change.
*/
`timescale 1ns/1ps
`default_nettype none
module phase_timer
#(
   parameter int W = 8
)
(
   // clock and reset
   input  wire logic         i_clk,
   input  wire logic         i_rst,
   // control
   input  wire logic         i_restart,
   input  wire logic [W-1:0] i_len,
   // status
   output logic              o_done,
   output logic              o_first
);

   logic [W-1:0] count_ff;

   // count cycles since the last restart, saturating at the end
   always_ff @(posedge i_clk or posedge i_rst)
   begin
      if (i_rst)
         count_ff <= '0;
      else if (i_restart)
         count_ff <= '0;
      else if (!o_done)
         count_ff <= count_ff + 1'b1;
   end

   assign o_done  = (count_ff == i_len - 1'b1);
   assign o_first = (count_ff == '0);

endmodule
`default_nettype wire

// ---- test/host_ctrl_properties.sv ----
/*
   pin-level assertions on the display host controller.
   assumes a bind to the top module with matching port names.
*/
`timescale 1ns/1ps
`default_nettype none
module host_ctrl_checker
(
   // clock and reset
   input wire logic            i_clk,
   input wire logic            i_rst,
   // device side
   input wire host_pkg::pins_s o_pins,
   input wire logic [7:0]      o_bus_out,
   input wire logic [7:0]      o_bus_oe_n
);
   logic [1:0] mode;
   logic       par;
   logic       m68;
   logic       ser;
   // strap decode, {high, low}
   assign mode = {o_pins.protocol_select_high,
                  o_pins.protocol_select_low};
   assign par  = o_pins.protocol_select_high;
   assign m68  = (mode == host_pkg::MODE_6800);
   assign ser  = (mode == host_pkg::MODE_SERIAL);

   default clocking cb @(posedge i_clk); endclocking
   default disable iff (i_rst);

   // ----------------------------------------------------------------
   // steps of an 8080 frame: quiet, strobe, quiet
   // ----------------------------------------------------------------
   sequence quiet4_s;
      (o_pins.rw && o_pins.e_rd)[*4];
   endsequence
   sequence strobe4_s;
      (o_pins.rw != o_pins.e_rd)[*4];
   endsequence

   serial_pins_low_a: assert property (
      !par |-> !o_pins.rw && !o_pins.e_rd) else $error("strobe not low");
   bus_release_a: assert property (
      par && o_bus_oe_n != 8'hff |-> !o_pins.cs_n) else $error("bus driven");
   read_quiet_a: assert property (
      m68 && !o_pins.cs_n && o_pins.rw |-> o_bus_oe_n == 8'hff)
      else $error("host drives during read");
   frame_6800_a: assert property (
      $fell(o_pins.cs_n) && m68 |-> ##4 o_pins.e_rd[*4] ##1 !o_pins.e_rd
      ##4 $rose(o_pins.cs_n)) else $error("6800 frame timing");
   frame_8080_a: assert property (
      $fell(o_pins.cs_n) && mode == host_pkg::MODE_8080 |-> quiet4_s ##1
      strobe4_s ##1 quiet4_s ##1 $rose(o_pins.cs_n))
      else $error("8080 frame timing");
   serial_frame_a: assert property (
      $fell(o_pins.cs_n) && ser |-> ##64 $rose(o_pins.cs_n))
      else $error("serial frame length");
   line_two_free_a: assert property (
      ser |-> o_bus_oe_n[2]) else $error("line 2 driven");
   serial_hold_a: assert property (
      ser && !o_pins.cs_n && o_bus_out[0] |-> $stable(o_bus_out[1]))
      else $error("data moved under clock");
   open_drain_a: assert property (
      mode == host_pkg::MODE_I2C |-> (o_bus_out & ~o_bus_oe_n) == 8'h00)
      else $error("i2c line driven high");
endmodule
`default_nettype wire

// ---- test/oled_device_model.sv ----
/*
   behavioural model of the display's host port.
   assumes host pins as seen on the wire; resolves the data lines.
*/
`timescale 1ns/1ps
`default_nettype none
module oled_device_model
#(
   parameter logic [7:0] RD_VAL = 8'ha5
)
(
   input wire logic            i_clk,
   input wire host_pkg::pins_s i_pins,
   input wire logic [7:0]      i_out,
   input wire logic [7:0]      i_oe_n,
   output logic     [7:0]      o_wire,
   output logic     [7:0]      o_byte,
   output logic                o_dc
);
   logic [1:0] mode;
   logic       sel;
   logic       dev_oe;
   logic       tog = 1'b0;
   logic [7:0] sh;
   int         cnt = 0;
   assign mode = {i_pins.protocol_select_high,
                  i_pins.protocol_select_low};
   assign sel = !i_pins.cs_n && i_pins.reset_n_input;
   // device drives only inside a selected read strobe
   assign dev_oe = sel && (mode == host_pkg::MODE_6800 ?
      i_pins.rw && i_pins.e_rd : mode == host_pkg::MODE_8080
      && !i_pins.e_rd);
   // free lines float: pulled up in i2c, else a pattern that moves
   always @(posedge i_clk)
      tog <= !tog;
   always_comb
   begin
      for (int k = 0; k < 8; k++)
         o_wire[k] = !i_oe_n[k] ? i_out[k] : dev_oe ? RD_VAL[k]
            : mode == host_pkg::MODE_I2C ? 1'b1 : tog;
      if (mode == host_pkg::MODE_I2C)
         o_wire[2:1] = {2{o_wire[1] & o_wire[2]}};
   end
   // reset clears the byte that was taken in
   always @(negedge i_pins.reset_n_input)
      o_byte <= 8'h00;
   // writes are taken at the closing edge of the strobe
   always @(negedge i_pins.e_rd)
      if (sel && mode == host_pkg::MODE_6800 && !i_pins.rw)
         {o_dc, o_byte} <= {i_pins.dc, o_wire};
   always @(posedge i_pins.rw)
      if (sel && mode == host_pkg::MODE_8080)
         {o_dc, o_byte} <= {i_pins.dc, o_wire};
   always @(negedge i_pins.cs_n)
      cnt = 0;
   // serial bits on the rising clock, msb first, dc at bit eight
   always @(posedge o_wire[0])
      if (sel && mode == host_pkg::MODE_SERIAL)
      begin
         sh = {sh[6:0], o_wire[1]};
         cnt = cnt + 1;
         if (cnt == 8)
            {o_dc, o_byte} <= {i_pins.dc, sh};
      end
endmodule
`default_nettype wire

// ---- test/oled_host_interface_front_end_tb.sv ----
/*
   self-checking bench for the display host controller.
   assumes the device model resolves the data lines.
*/
`timescale 1ns/1ps
`default_nettype none
module oled_host_interface_front_end_tb;
   localparam logic [7:0] RDV = 8'ha5;
   localparam logic [1:0] MDS [4] = '{host_pkg::MODE_6800,
      host_pkg::MODE_8080, host_pkg::MODE_SERIAL, host_pkg::MODE_I2C};
   logic            i_clk = 1'b0;
   logic            i_rst = 1'b1;
   logic [7:0]      addr = 8'h00;
   logic [31:0]     wdata = 32'h0;
   logic            wr = 1'b0;
   logic            rd = 1'b0;
   logic [31:0]     rdata;
   logic [31:0]     got;
   host_pkg::pins_s pins;
   logic [7:0]      wire_lv;
   logic [7:0]      bus_out;
   logic [7:0]      oe_n;
   logic [7:0]      dev_byte;
   logic            dev_dc;
   int              failures = 0;
   int              cmp_count = 0;

   always #25 i_clk = !i_clk;

   oled_host_ctrl dut_u
   (
      .i_clk      (i_clk),
      .i_rst      (i_rst),
      .i_addr     (addr),
      .i_wdata    (wdata),
      .i_wr       (wr),
      .i_rd       (rd),
      .o_rdata    (rdata),
      .o_pins     (pins),
      .i_bus_in   (wire_lv),
      .o_bus_out  (bus_out),
      .o_bus_oe_n (oe_n)
   );
   oled_device_model #(.RD_VAL(RDV)) dev_u
   (
      .i_clk  (i_clk),
      .i_pins (pins),
      .i_out  (bus_out),
      .i_oe_n (oe_n),
      .o_wire (wire_lv),
      .o_byte (dev_byte),
      .o_dc   (dev_dc)
   );

   // ----------------------------------------------------------------
   // register port and checking tasks
   // ----------------------------------------------------------------
   task automatic complete_run;
      if (failures == 0 && cmp_count > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask
   task automatic chk(input string what, input logic [31:0] seen,
                      input logic [31:0] exp);
      cmp_count++;
      if (seen !== exp)
      begin
         failures++;
         $display("MISMATCH %s exp %h seen %h", what, exp, seen);
      end
   endtask
   task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge i_clk);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge i_clk);
      wr <= 1'b0;
   endtask
   // read data stand only in the cycle after the strobe
   task automatic reg_rd(input logic [7:0] a);
      @(posedge i_clk);
      addr <= a;
      rd <= 1'b1;
      @(posedge i_clk);
      rd <= 1'b0;
      #1 got = rdata;
   endtask
   // poll busy; the longest frame is under 3000 cycles
   task automatic wait_idle;
      int n;
      n = 0;
      do
      begin
         reg_rd(host_pkg::ADDR_STATUS);
         n++;
      end
      while (got[host_pkg::STAT_BUSY] !== 1'b0 && n < 2000);
      if (n >= 2000)
      begin
         failures++;
         complete_run();
      end
   endtask

   // ----------------------------------------------------------------
   // main sequence
   // ----------------------------------------------------------------
   initial
   begin
      logic [1:0] m;
      logic [7:0] b;
      repeat (8) @(posedge i_clk);
      i_rst <= 1'b0;
      reg_rd(host_pkg::ADDR_CTRL);
      chk("ctrl reset", got, 32'h8);
      chk("reset pin", pins.reset_n_input, 1'b0);
      chk("cs idle", pins.cs_n, 1'b1);
      reg_rd(8'h14);
      chk("unmapped", got, 32'h0);
      // a transfer asked for while the device is held is refused
      reg_wr(host_pkg::ADDR_TXDATA, 32'h55);
      reg_rd(host_pkg::ADDR_STATUS);
      chk("held status", got, 32'h4);
      for (int i = 0; i < 8; i++)
      begin
         m = MDS[i / 2];
         b = i[0] ? 8'h96 : 8'h3c;
         reg_wr(host_pkg::ADDR_CTRL, {27'h0, i[0], 1'b0, i[0], m});
         reg_wr(host_pkg::ADDR_TXDATA, {24'h0, b});
         wait_idle();
         chk("straps", {pins.protocol_select_high,
             pins.protocol_select_low}, m);
         chk("reset pin", pins.reset_n_input, 1'b1);
         chk("dc pin", pins.dc, i[0]);
         chk("cs idle", pins.cs_n, 1'b1);
         if (m == host_pkg::MODE_I2C)
         begin
            reg_rd(host_pkg::ADDR_STATUS);
            chk("nack", got[host_pkg::STAT_NACK], 1'b1);
            reg_wr(host_pkg::ADDR_STATUS, 32'h2);
            reg_rd(host_pkg::ADDR_STATUS);
            chk("nack clear", got, 32'h0);
         end
         else
         begin
            chk("byte", dev_byte, b);
            chk("dc seen", dev_dc, i[0]);
         end
         if (m[1])
         begin
            reg_wr(host_pkg::ADDR_CMD, 32'h1);
            wait_idle();
            reg_rd(host_pkg::ADDR_RXDATA);
            chk("read back", got, {24'h0, RDV});
         end
      end
      complete_run();
   end
endmodule

bind oled_host_ctrl host_ctrl_checker chk_u
(
   .i_clk      (i_clk),
   .i_rst      (i_rst),
   .o_pins     (o_pins),
   .o_bus_out  (o_bus_out),
   .o_bus_oe_n (o_bus_oe_n)
);
`default_nettype wire
